//--- common/clock_cfg_cfg.svh
`ifndef CLOCK_CFG_CFG_SVH
`define CLOCK_CFG_CFG_SVH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define CLKCFG_ADDR_W          12
`define CLKCFG_DATA_W          32
`define CLKCFG_REG_W           16

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CLKCFG_OSC_CTRL_ADDR   12'h000
`define CLKCFG_CLK_DIV_ADDR    12'h004
`define CLKCFG_PLL_FBD_ADDR    12'h008

// ----------------------------------------------------------------------
// Oscillator control field positions
// ----------------------------------------------------------------------
`define CLKCFG_OSC_SWREQ_BIT   0
`define CLKCFG_OSC_SECEN_BIT   1
`define CLKCFG_OSC_NEWSRC_LSB  8
`define CLKCFG_OSC_NEWSRC_MSB  10
`define CLKCFG_OSC_CURSRC_LSB  12
`define CLKCFG_OSC_CURSRC_MSB  14

// ----------------------------------------------------------------------
// Clock divisor field positions
// ----------------------------------------------------------------------
`define CLKCFG_DIV_PRE_LSB     0
`define CLKCFG_DIV_PRE_MSB     4
`define CLKCFG_DIV_POST_LSB    6
`define CLKCFG_DIV_POST_MSB    7
`define CLKCFG_DIV_FRC_LSB     8
`define CLKCFG_DIV_FRC_MSB     10
`define CLKCFG_DIV_REDEN_BIT   11
`define CLKCFG_DIV_RED_LSB     12
`define CLKCFG_DIV_RED_MSB     14
`define CLKCFG_DIV_ROI_BIT     15

// ----------------------------------------------------------------------
// Feedback divisor field positions
// ----------------------------------------------------------------------
`define CLKCFG_FBD_MUL_LSB     0
`define CLKCFG_FBD_MUL_MSB     8

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define CLKCFG_OSC_CTRL_RESET  16'h0000
`define CLKCFG_CLK_DIV_RESET   16'h3040
`define CLKCFG_PLL_FBD_RESET   16'h0030
`define CLKCFG_POST_RESERVED   2'h2
`define CLKCFG_DIV_OFFSET      2
`define CLKCFG_SWITCH_CYCLES   4
`define CLKCFG_SETTLE_W        8
`define CLKCFG_MONITOR_ON      1'b0

`endif

//--- common/clock_cfg_pkg.sv
package clock_cfg_pkg;

   // One-hot states of the clock switch sequence.
   typedef enum logic [1:0] {
      SW_IDLE   = 2'b01,
      SW_ACTIVE = 2'b10
   } switch_state_t;

   // Whole state of the configuration block.
   typedef struct packed {
      switch_state_t sw_state;
      logic [7:0]    settle_count;
      logic [2:0]    switch_target;
      logic [2:0]    current_source;
      logic [2:0]    new_source_select;
      logic          secondary_osc_enable;
      logic          switch_request;
      logic          recover_on_interrupt;
      logic [2:0]    reduction_select;
      logic          reduction_enable;
      logic [2:0]    internal_rc_postscale;
      logic [1:0]    vco_output_divide;
      logic [4:0]    phase_detector_prescale;
      logic [8:0]    feedback_multiplier;
      logic [8:0]    frc_divisor;
      logic [5:0]    pll_pre_div;
      logic [3:0]    pll_post_div;
      logic [9:0]    pll_mult;
      logic [31:0]   prdata;
      logic          pslverr;
   } cfg_state_t;

   // Whole state of the processor clock reduction divider.
   typedef struct packed {
      logic [7:0] count;
      logic       pulse;
   } reduce_state_t;

   // Two raised to a three-bit exponent, 1 to 128.
   function automatic logic [8:0] pow2(input logic [2:0] e);
      return 9'h001 << e;
   endfunction

endpackage

//--- rtl/reduction_divider.sv
`timescale 1ns/1ps
`include "clock_cfg_cfg.svh"

module reduction_divider
   import clock_cfg_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enable,
   input  wire logic [2:0] select,
   output logic            cpu_clock_enable
);

   reduce_state_t state;
   reduce_state_t next_state;
   logic [8:0]    ratio;

   // ----------------------------------------------------------------------
   // Ratio counter
   // ----------------------------------------------------------------------
   // Disabled reduction gives a pulse on every cycle, so the processor
   // runs at the peripheral rate whatever the select field holds.
   always_comb begin
      next_state = state;
      ratio      = pow2(select);
      if (!enable) begin
         next_state.count = 8'h00;
         next_state.pulse = 1'b1;
      end else if ({1'b0, state.count} >= ratio - 9'h001) begin
         next_state.count = 8'h00;
         next_state.pulse = 1'b1;
      end else begin
         next_state.count = state.count + 8'h01;
         next_state.pulse = 1'b0;
      end
   end

   // Register the whole divider state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '{count: 8'h00, pulse: 1'b1};
      end else begin
         state <= next_state;
      end
   end

   assign cpu_clock_enable = state.pulse;

endmodule

//--- rtl/clock_divider_pll_config.sv
`timescale 1ns/1ps
`include "clock_cfg_cfg.svh"


module clock_divider_pll_config
   import clock_cfg_pkg::*;
#(
   parameter int SWITCH_CYCLES = `CLKCFG_SWITCH_CYCLES
)
(
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [`CLKCFG_ADDR_W-1:0]  paddr,
   input  wire logic [`CLKCFG_DATA_W-1:0]  pwdata,
   output logic      [`CLKCFG_DATA_W-1:0]  prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       switch_monitor_config,
   input  wire logic                       interrupt_event,
   output logic                            secondary_osc_enable,
   output logic      [2:0]                 clock_source_select,
   output logic                            clock_switch_busy,
   output logic                            cpu_clock_enable,
   output logic      [8:0]                 frc_divisor,
   output logic      [5:0]                 pll_prescale_divisor,
   output logic      [3:0]                 pll_postscale_divisor,
   output logic      [9:0]                 pll_multiplier
);

   // ----------------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------------
   localparam logic [7:0] SETTLE_LAST = 8'(SWITCH_CYCLES - 1);
   // A literal cannot be sliced, so the reset words are named here.
   localparam logic [15:0] OSC_RESET = `CLKCFG_OSC_CTRL_RESET;
   localparam logic [15:0] DIV_RESET = `CLKCFG_CLK_DIV_RESET;
   localparam logic [15:0] FBD_RESET = `CLKCFG_PLL_FBD_RESET;

   cfg_state_t state;
   cfg_state_t next_state;
   logic       setup_phase;
   logic       write_taken;
   logic [15:0] wdata;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Address decode is shared by the write path and the error path.
   function automatic logic addr_mapped(input logic [`CLKCFG_ADDR_W-1:0] a);
      return (a == `CLKCFG_OSC_CTRL_ADDR) ||
             (a == `CLKCFG_CLK_DIV_ADDR)  ||
             (a == `CLKCFG_PLL_FBD_ADDR);
   endfunction

   // Postscaler code to divide ratio; the reserved code never gets stored.
   function automatic logic [3:0] post_ratio(input logic [1:0] code);
      logic [3:0] r;
      case (code)
         2'b00:   r = 4'h2;
         2'b01:   r = 4'h4;
         2'b11:   r = 4'h8;
         default: r = 4'h4;
      endcase
      return r;
   endfunction

   // Assemble the oscillator control word; unused bits stay zero.
   function automatic logic [15:0] osc_word(input cfg_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[`CLKCFG_OSC_CURSRC_MSB:`CLKCFG_OSC_CURSRC_LSB] = s.current_source;
      w[`CLKCFG_OSC_NEWSRC_MSB:`CLKCFG_OSC_NEWSRC_LSB] =
         s.new_source_select;
      w[`CLKCFG_OSC_SECEN_BIT] = s.secondary_osc_enable;
      w[`CLKCFG_OSC_SWREQ_BIT] = s.switch_request;
      return w;
   endfunction

   // Assemble the clock divisor word; bit 5 is unimplemented.
   function automatic logic [15:0] div_word(input cfg_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[`CLKCFG_DIV_ROI_BIT] = s.recover_on_interrupt;
      w[`CLKCFG_DIV_RED_MSB:`CLKCFG_DIV_RED_LSB] = s.reduction_select;
      w[`CLKCFG_DIV_REDEN_BIT] = s.reduction_enable;
      w[`CLKCFG_DIV_FRC_MSB:`CLKCFG_DIV_FRC_LSB] =
         s.internal_rc_postscale;
      w[`CLKCFG_DIV_POST_MSB:`CLKCFG_DIV_POST_LSB] = s.vco_output_divide;
      w[`CLKCFG_DIV_PRE_MSB:`CLKCFG_DIV_PRE_LSB] =
         s.phase_detector_prescale;
      return w;
   endfunction

   // Assemble the feedback divisor word; bits 15 to 9 are unimplemented.
   function automatic logic [15:0] fbd_word(input cfg_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[`CLKCFG_FBD_MUL_MSB:`CLKCFG_FBD_MUL_LSB] = s.feedback_multiplier;
      return w;
   endfunction

   // ----------------------------------------------------------------------
   // Bus phases
   // ----------------------------------------------------------------------
   // Read data is captured in the setup cycle so that prdata comes from a
   // flop; this costs nothing since the access phase answers at once.
   assign setup_phase = psel & ~penable;
   assign pready      = psel & penable;
   assign write_taken = psel & penable & pwrite & addr_mapped(paddr);
   assign wdata       = pwdata[15:0];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_state = state;

      // Read data and error flag are prepared during setup.
      if (setup_phase) begin
         next_state.pslverr = ~addr_mapped(paddr);
         next_state.prdata  = 32'h0000_0000;
         case (paddr)
            `CLKCFG_OSC_CTRL_ADDR: next_state.prdata[15:0] = osc_word(state);
            `CLKCFG_CLK_DIV_ADDR:  next_state.prdata[15:0] = div_word(state);
            `CLKCFG_PLL_FBD_ADDR:  next_state.prdata[15:0] = fbd_word(state);
            default:               next_state.prdata = 32'h0000_0000;
         endcase
      end

      // Oscillator control write. Only the implemented fields are taken.
      if (write_taken && paddr == `CLKCFG_OSC_CTRL_ADDR) begin
         next_state.new_source_select =
            wdata[`CLKCFG_OSC_NEWSRC_MSB:`CLKCFG_OSC_NEWSRC_LSB];
         next_state.secondary_osc_enable =
            wdata[`CLKCFG_OSC_SECEN_BIT];
         // A request is honoured only when switching is allowed and no
         // switch is already running; otherwise the bit keeps its value.
         if (wdata[`CLKCFG_OSC_SWREQ_BIT] &&
             switch_monitor_config == `CLKCFG_MONITOR_ON &&
             state.sw_state == SW_IDLE) begin
            next_state.switch_request = 1'b1;
            next_state.switch_target  =
               wdata[`CLKCFG_OSC_NEWSRC_MSB:`CLKCFG_OSC_NEWSRC_LSB];
            next_state.settle_count   = 8'h00;
            next_state.sw_state       = SW_ACTIVE;
         end
      end

      // Clock divisor write.
      if (write_taken && paddr == `CLKCFG_CLK_DIV_ADDR) begin
         next_state.recover_on_interrupt = wdata[`CLKCFG_DIV_ROI_BIT];
         next_state.reduction_select =
            wdata[`CLKCFG_DIV_RED_MSB:`CLKCFG_DIV_RED_LSB];
         next_state.reduction_enable = wdata[`CLKCFG_DIV_REDEN_BIT];
         next_state.internal_rc_postscale =
            wdata[`CLKCFG_DIV_FRC_MSB:`CLKCFG_DIV_FRC_LSB];
         // The reserved postscaler code would leave the PLL output
         // undefined, so such a write keeps the previous setting.
         if (wdata[`CLKCFG_DIV_POST_MSB:`CLKCFG_DIV_POST_LSB] !=
             `CLKCFG_POST_RESERVED) begin
            next_state.vco_output_divide =
               wdata[`CLKCFG_DIV_POST_MSB:`CLKCFG_DIV_POST_LSB];
         end
         next_state.phase_detector_prescale =
            wdata[`CLKCFG_DIV_PRE_MSB:`CLKCFG_DIV_PRE_LSB];
      end

      // Feedback divisor write.
      if (write_taken && paddr == `CLKCFG_PLL_FBD_ADDR) begin
         next_state.feedback_multiplier =
            wdata[`CLKCFG_FBD_MUL_MSB:`CLKCFG_FBD_MUL_LSB];
      end

      // Interrupt recovery. Placed after the software write so that an
      // interrupt in the same cycle as a write still drops reduction.
      if (state.recover_on_interrupt && interrupt_event) begin
         next_state.reduction_enable = 1'b0;
      end

      // Clock switch sequence: wait the settle time, then move over.
      case (state.sw_state)
         SW_IDLE: begin
         end
         SW_ACTIVE: begin
            if (state.settle_count >= SETTLE_LAST) begin
               next_state.current_source = state.switch_target;
               next_state.switch_request = 1'b0;
               next_state.sw_state       = SW_IDLE;
            end else begin
               next_state.settle_count = state.settle_count + 8'h01;
            end
         end
         default: begin
            next_state.sw_state       = SW_IDLE;
            next_state.switch_request = 1'b0;
         end
      endcase

      // Decoded divide ratios follow the stored fields in the same cycle.
      next_state.frc_divisor =
         pow2(next_state.internal_rc_postscale);
      next_state.pll_pre_div =
         6'({1'b0, next_state.phase_detector_prescale}) +
         6'(`CLKCFG_DIV_OFFSET);
      next_state.pll_post_div =
         post_ratio(next_state.vco_output_divide);
      next_state.pll_mult =
         10'({1'b0, next_state.feedback_multiplier}) +
         10'(`CLKCFG_DIV_OFFSET);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Reset values give the documented divide defaults: /8 reduction
   // select, /4 postscaler, /2 prescaler and a multiplier of 50.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.sw_state                <= SW_IDLE;
         state.settle_count            <= 8'h00;
         state.switch_target           <= 3'h0;
         state.current_source          <= 3'h0;
         state.new_source_select       <= OSC_RESET
            [`CLKCFG_OSC_NEWSRC_MSB:`CLKCFG_OSC_NEWSRC_LSB];
         state.secondary_osc_enable    <= OSC_RESET
            [`CLKCFG_OSC_SECEN_BIT];
         state.switch_request          <= 1'b0;
         state.recover_on_interrupt    <= DIV_RESET
            [`CLKCFG_DIV_ROI_BIT];
         state.reduction_select        <= DIV_RESET
            [`CLKCFG_DIV_RED_MSB:`CLKCFG_DIV_RED_LSB];
         state.reduction_enable        <= DIV_RESET
            [`CLKCFG_DIV_REDEN_BIT];
         state.internal_rc_postscale   <= DIV_RESET
            [`CLKCFG_DIV_FRC_MSB:`CLKCFG_DIV_FRC_LSB];
         state.vco_output_divide       <= DIV_RESET
            [`CLKCFG_DIV_POST_MSB:`CLKCFG_DIV_POST_LSB];
         state.phase_detector_prescale <= DIV_RESET
            [`CLKCFG_DIV_PRE_MSB:`CLKCFG_DIV_PRE_LSB];
         state.feedback_multiplier     <= FBD_RESET
            [`CLKCFG_FBD_MUL_MSB:`CLKCFG_FBD_MUL_LSB];
         state.frc_divisor             <= 9'h001;
         state.pll_pre_div             <= 6'h02;
         state.pll_post_div            <= 4'h4;
         state.pll_mult                <= 10'h032;
         state.prdata                  <= 32'h0000_0000;
         state.pslverr                 <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------------
   // Processor clock reduction
   // ----------------------------------------------------------------------
   reduction_divider u_reduction (
      .pclk             (pclk),
      .presetn          (presetn),
      .enable           (state.reduction_enable),
      .select           (state.reduction_select),
      .cpu_clock_enable (cpu_clock_enable)
   );

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Every output below is a flop of the state record.
   assign prdata                = state.prdata;
   assign pslverr               = state.pslverr;
   assign secondary_osc_enable  = state.secondary_osc_enable;
   assign clock_source_select   = state.current_source;
   assign clock_switch_busy     = state.switch_request;
   assign frc_divisor           = state.frc_divisor;
   assign pll_prescale_divisor  = state.pll_pre_div;
   assign pll_postscale_divisor = state.pll_post_div;
   assign pll_multiplier        = state.pll_mult;

endmodule

//--- testbench/clock_cfg_properties.sv
`timescale 1ns/1ps
`include "clock_cfg_cfg.svh"

module clock_cfg_properties
#(
   parameter int SWITCH_CYCLES = `CLKCFG_SWITCH_CYCLES
)
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        switch_monitor_config,
   input wire logic        interrupt_event,
   input wire logic        secondary_osc_enable,
   input wire logic [2:0]  clock_source_select,
   input wire logic        clock_switch_busy,
   input wire logic        cpu_clock_enable,
   input wire logic [8:0]  frc_divisor,
   input wire logic [5:0]  pll_prescale_divisor,
   input wire logic [3:0]  pll_postscale_divisor,
   input wire logic [9:0]  pll_multiplier
);
   // ----------------------------------------------------------------
   // Shadow registers
   // ----------------------------------------------------------------
   logic [15:0] div_sh;
   logic [8:0]  fbd_sh;
   logic [2:0]  tgt;
   logic [7:0]  busy_cnt;
   logic [7:0]  off_cnt;
   logic [1:0]  quiet;
   logic        wr;
   logic        start;

   // A switch only starts when it is allowed and none is running.
   assign wr = psel && penable && pwrite;
   assign start = wr && paddr == `CLKCFG_OSC_CTRL_ADDR && pwdata[0] &&
                  !switch_monitor_config && !clock_switch_busy;

   // Shadows let divisor outputs be judged without seeing the fields.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_sh   <= `CLKCFG_CLK_DIV_RESET;
         fbd_sh   <= 9'h030;
         tgt      <= 3'h0;
         busy_cnt <= 8'h00;
         off_cnt  <= 8'h00;
         quiet    <= 2'h0;
      end else begin
         busy_cnt <= clock_switch_busy ? busy_cnt + 8'h01 : 8'h00;
         off_cnt  <= div_sh[11] ? 8'h00 : off_cnt + {7'h0, off_cnt != 8'hFF};
         quiet    <= wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
         if (start) tgt <= pwdata[10:8];
         if (wr && paddr == `CLKCFG_PLL_FBD_ADDR) fbd_sh <= pwdata[8:0];
         if (wr && paddr == `CLKCFG_CLK_DIV_ADDR) begin
            div_sh <= pwdata[15:0] & 16'hFFDF;
            if (pwdata[7:6] == `CLKCFG_POST_RESERVED) div_sh[7:6] <= div_sh[7:6];
         end
         if (div_sh[15] && interrupt_event) div_sh[11] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_switch_start: assert property (
      start |=> clock_switch_busy) else $error("Switch did not start.");
   a_switch_blocked: assert property (
      $rose(clock_switch_busy) |-> !$past(switch_monitor_config))
      else $error("Switch started while blocked.");
   a_switch_bound: assert property (
      clock_switch_busy |-> busy_cnt < SWITCH_CYCLES)
      else $error("Switch request never cleared.");
   a_switch_length: assert property (
      $fell(clock_switch_busy) |-> busy_cnt == SWITCH_CYCLES)
      else $error("Switch ended early.");
   a_switch_target: assert property (
      $fell(clock_switch_busy) |-> clock_source_select == tgt)
      else $error("Wrong clock source after switch.");
   a_secondary_en: assert property (
      wr && paddr == `CLKCFG_OSC_CTRL_ADDR |=>
      secondary_osc_enable == $past(pwdata[1]))
      else $error("Secondary oscillator enable wrong.");
   a_ratio_one: assert property (
      off_cnt > 8'h82 |-> cpu_clock_enable)
      else $error("Processor clock reduced while disabled.");
   a_rc_post: assert property (
      quiet == 2'h3 |-> frc_divisor == (9'h001 << div_sh[10:8]))
      else $error("Internal RC divisor wrong.");
   a_pll_pre: assert property (
      quiet == 2'h3 |-> pll_prescale_divisor == {1'b0, div_sh[4:0]} + 6'h02)
      else $error("Prescale divisor wrong.");
   a_pll_post: assert property (
      quiet == 2'h3 |-> pll_postscale_divisor ==
      (div_sh[7] ? 4'h8 : (div_sh[6] ? 4'h4 : 4'h2)))
      else $error("Postscale divisor wrong.");
   a_pll_mult: assert property (
      quiet == 2'h3 |-> pll_multiplier == {1'b0, fbd_sh} + 10'h002)
      else $error("Multiplier wrong.");

   c_switch: cover property ($rose(clock_switch_busy));
   c_recover: cover property ($fell(div_sh[11]) && $past(interrupt_event));
   c_unmapped: cover property (wr && paddr == 12'h00C);
endmodule

bind clock_divider_pll_config clock_cfg_properties #(
   .SWITCH_CYCLES(SWITCH_CYCLES)
) clock_cfg_properties_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .switch_monitor_config(switch_monitor_config),
   .interrupt_event(interrupt_event),
   .secondary_osc_enable(secondary_osc_enable),
   .clock_source_select(clock_source_select),
   .clock_switch_busy(clock_switch_busy),
   .cpu_clock_enable(cpu_clock_enable), .frc_divisor(frc_divisor),
   .pll_prescale_divisor(pll_prescale_divisor),
   .pll_postscale_divisor(pll_postscale_divisor),
   .pll_multiplier(pll_multiplier)
);

//--- testbench/testbench.sv
`timescale 1ns/1ps
`include "clock_cfg_cfg.svh"

module testbench;
   localparam int SW = 8;
   localparam int LIMIT = 8000;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [15:0] q;
   } row_t;
   // Write, then the value that reads back.
   row_t rows [0:8] = '{
      {12'h000, 32'h0000FFFE, 16'h0702}, {12'h000, 32'h00000000, 16'h0000},
      {12'h004, 32'hFFFFFFFF, 16'hFFDF}, {12'h004, 32'h00000080, 16'h00C0},
      {12'h004, 32'h0000061F, 16'h061F}, {12'h004, 32'h00003040, 16'h3040},
      {12'h008, 32'hFFFFFFFF, 16'h01FF}, {12'h008, 32'h00000000, 16'h0000},
      {12'h008, 32'h00000030, 16'h0030}};
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        monitor = 1'b1;
   logic        irq = 1'b0;
   logic        sec_en;
   logic [2:0]  src;
   logic        busy;
   logic        cpu_en;
   logic [8:0]  fast_internal_rc;
   logic [5:0]  pre;
   logic [3:0]  post;
   logic [9:0]  mult;
   logic [31:0] rd;
   logic        er;
   logic [15:0] osc;
   logic [15:0] div;
   logic [15:0] fbd;
   int          fail_count = 0;
   int          compares = 0;
   int          cycle = 0;
   int          t0;
   int          n;

   clock_divider_pll_config #(.SWITCH_CYCLES(SW)) clock_divider_pll_config_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .switch_monitor_config(monitor),
      .interrupt_event(irq), .secondary_osc_enable(sec_en),
      .clock_source_select(src), .clock_switch_busy(busy),
      .cpu_clock_enable(cpu_en), .frc_divisor(fast_internal_rc),
      .pll_prescale_divisor(pre), .pll_postscale_divisor(post),
      .pll_multiplier(mult));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   always #50 pclk = ~pclk;

   // A hung wait is cut short here and still gives a verdict.
   always @(posedge pclk) begin
      cycle <= cycle + 1;
      if (cycle == LIMIT) begin
         fail_count++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; an idle cycle follows so psel is never set twice.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [31:0] ports_of(input logic [15:0] dv,
                                            input logic [15:0] fb);
      logic [3:0] p;
      p = dv[7] ? 4'h8 : (dv[6] ? 4'h4 : 4'h2);
      return {3'h0, 9'h001 << dv[10:8], {1'b0, dv[4:0]} + 6'h02, p,
              {1'b0, fb[8:0]} + 10'h002};
   endfunction

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      osc = 16'h0000;
      div = `CLKCFG_CLK_DIV_RESET;
      fbd = `CLKCFG_PLL_FBD_RESET;
      check({3'h0, fast_internal_rc, pre, post, mult}, ports_of(div, fbd));
      check({cpu_en, busy, sec_en, src}, 6'h20);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check(rd, i == 0 ? 32'h0 : (i == 1 ? div : fbd));
      end
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         check(rd, {16'h0, rows[i].q});
         if (rows[i].a == 12'h000) osc = rows[i].q;
         if (rows[i].a == 12'h004) div = rows[i].q;
         if (rows[i].a == 12'h008) fbd = rows[i].q;
         repeat (4) @(posedge pclk);
         check({3'h0, fast_internal_rc, pre, post, mult}, ports_of(div, fbd));
         check(sec_en, osc[1]);
      end
      // Unmapped word: refused, reads zero.
      apb(1'b1, 12'h00C, 32'hFFFF);
      check(er, 1'b1);
      apb(1'b0, 12'h00C, 32'h0);
      check(er, 1'b1);
      check(rd, 32'h0);
      // A switch request must be ignored while switching is locked.
      apb(1'b1, 12'h000, 32'h0401);
      check(busy, 1'b0);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h0400);
      monitor <= 1'b0;
      apb(1'b1, 12'h000, 32'h0501);
      t0 = cycle;
      apb(1'b0, 12'h000, 32'h0);
      check(rd[0], 1'b1);
      while (busy === 1'b1) @(posedge pclk);
      check(cycle - t0, SW);
      check(src, 3'h5);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h5500);
      // Interrupt clears reduction only when recovery is set.
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 12'h004, k ? 32'hB840 : 32'h3840);
         irq <= 1'b1;
         @(posedge pclk);
         irq <= 1'b0;
         apb(1'b0, 12'h004, 32'h0);
         check(rd, k ? 32'hB040 : 32'h3840);
      end
      // Processor clock pulses per 256 cycles for each ratio, then off.
      for (int s = 0; s < 9; s++) begin
         apb(1'b1, 12'h004, s < 8 ? 32'h0840 | (s << 12) : 32'h7040);
         repeat (130) @(posedge pclk);
         n = 0;
         repeat (256) begin
            @(posedge pclk);
            if (cpu_en === 1'b1) n++;
         end
         check(n, 256 >> (s < 8 ? s : 0));
      end
      // A second reset restores the divisor register.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h3040);
      conclude();
   end
endmodule
